// ---- hdl/mem_read_defines.vh ----
// Constants for the two-wire serial memory read path
// Notes on behaviour
// - Read slave address starts output from current address
// - Latch keeps 15 bits; top bit from slave
// - Address counter increments as each read byte starts to go out
// - Master acknowledge requests next sequential byte
// - Valid endings release data; otherwise keep driving
// - Lower half wraps 7FFF to 0000
// - Upper half wraps FFFF to 8000
// - Write slave address then address bytes load latch
// - Repeated start after address aborts write, no store
// - Select bits match pins; bit1 top address; bit0 direction
// - Upper four bits fixed type code must match
// - First address byte bits 14..8, second 7..0
// - Bytes move most significant bit first
`ifndef MEM_READ_DEFINES_VH
`define MEM_READ_DEFINES_VH
// Bit positions inside the slave address byte
`define SA_TYPE_HI 7
`define SA_TYPE_LO 4
`define SA_SEL_HI 3
`define SA_SEL_LO 2
`define SA_TOP_BIT 1
`define SA_RW_BIT 0
// Reset value of the address latch
`define ADDR_RESET 15'h0000
// Index of the last bit of a byte
`define BYTE_LAST_BIT 3'h7
`endif

// ---- hdl/serial_memory_read_path.v ----
// Read path of a two-wire serial byte memory, slave side
`timescale 1ns/100ps
`include "mem_read_defines.vh"
module serial_memory_read_path #(
  parameter [3:0] TYPE_CODE = 4'h5, // Device type code; value arbitrary
  parameter AW = 16 // Full memory address width
) (
  input wire sys_clk, // System clock, 10 MHz
  input wire rst_n, // Asynchronous reset, active low
  input wire scl_in, // Bus clock pin level
  input wire sda_in, // Bus data pin level
  output reg sda_out, // Data pin drive value (always low when enabled)
  output reg sda_oe, // High while this block pulls data low
  input wire select_pin_low, // Device select pin, slave address bit 2
  input wire select_pin_high, // Device select pin, slave address bit 3
  output reg [AW-1:0] mem_addr, // Address of the byte being fetched
  output wire mem_rd, // Fetch strobe, one cycle
  input wire [7:0] mem_rdata, // Byte at mem_addr, valid next cycle
  output reg [AW-2:0] addr_latch // Current address latch
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] scl_sync; // Two-stage clock synchroniser
  reg [1:0] sda_sync; // Two-stage data synchroniser
  reg scl_d; // Previous synchronised clock
  reg sda_d; // Previous synchronised data
  reg [1:0] sel_sync0; // First stage for select pins
  reg [1:0] sel_sync1; // Second stage for select pins

  // Pins are asynchronous to sys_clk, so two flops before any use
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sel_sync0 <= 2'h0;
      sel_sync1 <= 2'h0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      sel_sync0 <= {select_pin_high, select_pin_low};
      sel_sync1 <= sel_sync0;
    end
  end

  wire scl = scl_sync[1]; // Clean bus clock
  wire sda = sda_sync[1]; // Clean bus data
  wire scl_rise = scl & ~scl_d; // Bit sample point
  wire scl_fall = ~scl & scl_d; // Data change point
  wire start_cond = scl & scl_d & sda_d & ~sda; // Start seen
  wire stop_cond = scl & scl_d & ~sda_d & sda; // Stop seen

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for start, line released
  localparam [2:0] ST_SLAVE = 3'h1; // Receiving slave address
  localparam [2:0] ST_ADDR_HI = 3'h2; // Receiving upper address byte
  localparam [2:0] ST_ADDR_LO = 3'h3; // Receiving lower address byte
  localparam [2:0] ST_WDATA = 3'h4; // Write data ignored on this path
  localparam [2:0] ST_READ = 3'h5; // Shifting data out
  localparam [2:0] ST_RACK = 3'h6; // Master acknowledge slot

  reg [2:0] state; // Current protocol phase
  reg [2:0] bit_cnt; // Bit index within byte
  reg [7:0] shift; // Receive or transmit shifter
  reg ack_phase; // Ninth clock under way; its closing fall is pending
  reg ack_pend; // Our acknowledge goes out at the next bus clock fall
  reg top_bit; // Top address bit from the slave address
  reg [6:0] addr_hi; // Held upper address byte
  reg fetch; // Fetch request, one cycle
  reg load_pend; // Fetched byte to load next cycle

  assign mem_rd = fetch;

  // Increment that stays inside the current half
  wire [AW-2:0] next_latch = addr_latch + 1'b1;

  // Incoming byte with the bit sampled at this rising edge
  wire [7:0] rx_byte = {shift[6:0], sda};

  // Sample on rising clock edges, change drive on falling edges
  // The latch steps only when a byte really starts to go out, so a
  // stop or start that cuts the ninth clock short leaves it pointing
  // just past the last byte delivered
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      ack_phase <= 1'b0;
      ack_pend <= 1'b0;
      top_bit <= 1'b0;
      addr_hi <= 7'h00;
      addr_latch <= `ADDR_RESET;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      fetch <= 1'b0;
      load_pend <= 1'b0;
      mem_addr <= {AW{1'b0}};
    end else begin
      fetch <= 1'b0;
      load_pend <= fetch;
      if (load_pend) begin
        shift <= mem_rdata;
      end
      if (start_cond) begin
        // Start aborts any transfer, including a write after address
        state <= ST_SLAVE;
        bit_cnt <= 3'h0;
        ack_phase <= 1'b0;
        ack_pend <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        ack_phase <= 1'b0;
        ack_pend <= 1'b0;
        sda_oe <= 1'b0;
      end else if (ack_pend) begin
        // Pull the line low through the ninth clock of an accepted byte
        if (scl_fall) begin
          ack_pend <= 1'b0;
          ack_phase <= 1'b1;
          sda_oe <= 1'b1;
        end
      end else if (ack_phase) begin
        // Release the line after our acknowledge, or drive first bit
        if (scl_fall) begin
          ack_phase <= 1'b0;
          if (state == ST_READ) begin
            sda_oe <= ~shift[7];
            shift <= {shift[6:0], 1'b0};
            // The byte is now on its way, so the latch moves past it;
            // the fifteen-bit add keeps the step inside the half
            addr_latch <= next_latch;
          end else begin
            sda_oe <= 1'b0;
          end
        end
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_SLAVE, ST_ADDR_HI, ST_ADDR_LO: begin
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `BYTE_LAST_BIT) begin
                ack_pend <= 1'b1;
                if (state == ST_SLAVE) begin
                  if (rx_byte[`SA_TYPE_HI:`SA_TYPE_LO] != TYPE_CODE ||
                      rx_byte[`SA_SEL_HI:`SA_SEL_LO] != sel_sync1) begin
                    state <= ST_IDLE;
                    ack_pend <= 1'b0;
                  end else begin
                    top_bit <= rx_byte[`SA_TOP_BIT];
                    if (rx_byte[`SA_RW_BIT]) begin
                      state <= ST_READ;
                      fetch <= 1'b1;
                      mem_addr <= {rx_byte[`SA_TOP_BIT], addr_latch};
                      // Latch steps when the first bit goes out
                    end else begin
                      state <= ST_ADDR_HI;
                    end
                  end
                end else if (state == ST_ADDR_HI) begin
                  addr_hi <= rx_byte[6:0];
                  state <= ST_ADDR_LO;
                end else begin
                  addr_latch <= {addr_hi, rx_byte};
                  state <= ST_WDATA;
                end
              end
            end
          end
          ST_WDATA: begin
            // Write data is outside this path; stay released
            sda_oe <= 1'b0;
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt == `BYTE_LAST_BIT) begin
                sda_oe <= 1'b0;
                state <= ST_RACK;
                bit_cnt <= 3'h0;
              end else begin
                sda_oe <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (!sda) begin
                // Acknowledge: fetch next byte and advance
                state <= ST_READ;
                ack_phase <= 1'b1;
                fetch <= 1'b1;
                mem_addr <= {top_bit, addr_latch};
                // A stop in this clock looks like an acknowledge until sda
                // rises, so the byte is only prefetched here and the latch
                // waits for the closing fall
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ---- verif/mem_read_monitor.sv ----
// Assertion checker for the serial memory read path
`timescale 1ns/100ps
module mem_read_monitor #(
  parameter AW = 16 // Memory address width
) (
  input wire sys_clk, // Clock
  input wire rst_n, // Reset, active low
  input wire scl_in, // Bus clock
  input wire sda_in, // Bus data
  input wire sda_out, // Drive value
  input wire sda_oe, // Pull enable
  input wire select_pin_low, // Select bit 2
  input wire select_pin_high, // Select bit 3
  input wire [AW-1:0] mem_addr, // Fetch address
  input wire mem_rd, // Fetch strobe
  input wire [7:0] mem_rdata, // Fetched byte
  input wire [AW-2:0] addr_latch // Address latch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A fetched byte must move the latch one step on, unless a start or stop
  // on the pins abandons it first; the wrap inside a half comes from the width
  reg armed; // Fetch waiting for its latch step
  reg [AW-2:0] exp_next; // Latch value that the fetch leads to
  reg [AW-2:0] latch_p; // Latch one cycle earlier
  reg scl_p; // Bus clock one cycle earlier
  reg sda_p; // Bus data one cycle earlier
  wire bus_cond = scl_in && scl_p && (sda_in != sda_p); // Start or stop on the pins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      exp_next <= {(AW-1){1'b0}};
      latch_p <= {(AW-1){1'b0}};
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_in;
      sda_p <= sda_in;
      latch_p <= addr_latch;
      if (mem_rd) begin
        armed <= 1'b1;
        exp_next <= mem_addr[AW-2:0] + 1'b1;
      end else if (bus_cond || addr_latch != latch_p) begin
        armed <= 1'b0;
      end
    end
  end
  // A driven or released bit lasts one bus period, lag jitter allowed
  sequence s_on; sda_oe [*7]; endsequence
  sequence s_off; !sda_oe [*7]; endsequence
  property p_drv_low; sda_oe |-> !sda_out; endproperty
  a_drv_low: assert property (p_drv_low) else $error("line driven high");
  property p_rd_pulse; mem_rd |=> !mem_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("fetch too long");
  // Fifteen-bit add keeps the half: 7FFF to 0000, FFFF to 8000
  property p_inc; armed && addr_latch != latch_p |-> addr_latch == exp_next; endproperty
  a_inc: assert property (p_inc) else $error("bad increment");
  property p_fetch; mem_rd |-> mem_addr[AW-2:0] == addr_latch; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not from latch");
  property p_keep; mem_rd |=> $stable(mem_addr); endproperty
  a_keep: assert property (p_keep) else $error("fetch address moved");
  // The line only moves after a bus clock fall, never in the high phase
  property p_edge; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
  a_edge: assert property (p_edge) else $error("line moved at high clock");
  property p_hold; $rose(scl_in) && sda_oe |-> sda_oe [*4]; endproperty
  a_hold: assert property (p_hold) else $error("bit not held");
  property p_on; $rose(sda_oe) |-> s_on; endproperty
  a_on: assert property (p_on) else $error("short low bit");
  property p_off; $fell(sda_oe) |-> s_off; endproperty
  a_off: assert property (p_off) else $error("short release");
endmodule
bind serial_memory_read_path mem_read_monitor #(.AW(AW)) i_mon (.sys_clk(sys_clk),
  .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .select_pin_low(select_pin_low), .select_pin_high(select_pin_high),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .addr_latch(addr_latch));

// ---- verif/bus_master_model.sv ----
// Two-wire bus master model, bus clock of eight system cycles
`timescale 1ns/100ps
module bus_master_model (
  input wire sys_clk, // System clock
  input wire sda, // Resolved data line
  output reg scl, // Bus clock, idle high
  output reg sda_low // High while pulling data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // All pin moves land on falling system edges
  task q(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Data falls while the clock is high
  task start;
    begin
      sda_low = 1'b0; q(2); scl = 1'b1; q(4); sda_low = 1'b1; q(4); scl = 1'b0; q(2);
    end
  endtask
  // Data rises while the clock is high; clock stays high after
  task stop;
    begin
      sda_low = 1'b1; q(2); scl = 1'b1; q(4); sda_low = 1'b0; q(4);
    end
  endtask
  // One bit: data set in the low phase, line sampled mid high phase
  task send_bit(input b, output r);
    begin
      sda_low = !b; q(2); scl = 1'b1; q(2); r = sda; q(2); scl = 1'b0; q(2);
    end
  endtask
  task xfer(input [7:0] d, output [7:0] r);
    integer i;
    reg v;
    for (i = 7; i >= 0; i = i - 1) begin
      send_bit(d[i], v);
      r[i] = v;
    end
  endtask
endmodule

// ---- verif/tb.sv ----
// Testbench for the serial memory read path
`timescale 1ns/100ps
module tb;
  localparam [3:0] TYPE = 4'h5; // Type code, value arbitrary
  reg sys_clk, rst_n, a; // Clock, reset, ninth bit seen
  reg [1:0] sel; // Select pin levels
  reg [7:0] r; // Byte seen
  integer err_count, tests_run;
  wire scl, m_low, sda_out, sda_oe, mem_rd;
  wire [15:0] mem_addr;
  wire [14:0] addr_latch;
  // Pattern differs between the two halves at every boundary address used below
  function [7:0] pat(input [15:0] x);
    pat = x[7:0] + {x[14:8], x[15]};
  endfunction
  wire sda = !(m_low || sda_oe); // Open drain, pulled up
  wire [7:0] mem_rdata = pat(mem_addr);
  serial_memory_read_path #(.TYPE_CODE(TYPE), .AW(16)) i_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_pin_low(sel[0]), .select_pin_high(sel[1]), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .addr_latch(addr_latch));
  bus_master_model i_bus (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Address byte, ninth bit released to the device
  task addr(input [7:0] b, input exp_a);
    begin
      i_bus.xfer(b, r);
      i_bus.send_bit(1'b1, a);
      chk(a, exp_a);
    end
  endtask
  task set_addr(input top, input [14:0] ad);
    begin
      i_bus.start;
      addr({TYPE, sel, top, 1'b0}, 1'b0);
      addr({1'b0, ad[14:8]}, 1'b0);
      addr(ad[7:0], 1'b0);
    end
  endtask
  task rd_begin(input top);
    begin
      i_bus.start;
      addr({TYPE, sel, top, 1'b1}, 1'b0);
    end
  endtask
  // Mode 0 ack, 1 nack, 2 no ninth clock
  task rd(input [15:0] ad, input [1:0] mode);
    begin
      i_bus.xfer(8'hFF, r);
      chk(r, pat(ad));
      if (mode < 2) begin
        i_bus.send_bit(mode[0], a);
        chk(a, mode[0]);
      end
    end
  endtask
  task t_lower;
    begin
      set_addr(1'b0, 15'h7FFE);
      rd_begin(1'b0);
      rd(16'h7FFE, 2'd0);
      rd(16'h7FFF, 2'd0);
      rd(16'h0000, 2'd1);
      i_bus.stop;
      chk(sda_oe, 1'b0);
      rd_begin(1'b1);
      rd(16'h8001, 2'd1);
    end
  endtask
  task t_upper;
    begin
      set_addr(1'b1, 15'h7FFF);
      rd_begin(1'b1);
      rd(16'hFFFF, 2'd0);
      rd(16'h8000, 2'd2);
      i_bus.stop;
      rd_begin(1'b0);
      rd(16'h0001, 2'd2);
    end
  endtask
  // Foreign select or type code is ignored; latch kept
  task t_miss;
    begin
      i_bus.start;
      chk(sda_oe, 1'b0);
      addr({TYPE, ~sel, 2'b01}, 1'b1);
      i_bus.xfer(8'hFF, r);
      chk(r, 8'hFF);
      i_bus.stop;
      i_bus.start;
      addr({TYPE ^ 4'h3, sel, 2'b01}, 1'b1);
      i_bus.stop;
      chk(addr_latch, 15'h0002);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    err_count = 0; tests_run = 0; rst_n = 1'b0; sel = 2'b10;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_lower; t_upper; t_miss;
    finish_test;
  end
  // Run needs about 1600 cycles; cut off well beyond
  initial begin
    #1000000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule
